// ==== hw/vic_pkg.sv ====
// Package of shared constants for the vectored interrupt controller
package vic_pkg;
  localparam int unsigned NUM_LINES    = 8;
  localparam logic [7:0]  CALL_OPCODE  = 8'hcd;
  // Init word one fields
  localparam int unsigned IW1_FOURTH   = 0;
  localparam int unsigned IW1_SINGLE   = 1;
  localparam int unsigned IW1_SPACING  = 2;
  localparam int unsigned IW1_LEVEL    = 3;
  localparam int unsigned IW1_TAG      = 4;
  // Init word four fields
  localparam int unsigned IW4_FAMILY   = 0;
  localparam int unsigned IW4_AUTO     = 1;
  localparam int unsigned IW4_MSEL     = 2;
  localparam int unsigned IW4_BUF      = 3;
  localparam int unsigned IW4_NEST     = 4;
  // Operation word fields
  localparam int unsigned OW2_DONE     = 5;
  localparam int unsigned OW3_SMM      = 5;
  localparam int unsigned OW3_ESMM     = 6;
  localparam int unsigned OW_SEL_BIT   = 3;
  // Register bus offsets (word index)
  localparam logic [2:0] REG_CMD       = 3'h0;
  localparam logic [2:0] REG_DATA      = 3'h1;
  localparam logic [2:0] REG_STATUS    = 3'h2;
  localparam logic [2:0] REG_VECTOR    = 3'h3;
  localparam logic [2:0] REG_ACK       = 3'h4;
  // Acknowledge pulse high width in ns, converted to cycles
  localparam int unsigned ACK_PULSE_NS = 300;
  localparam int unsigned CLK_NS       = 5;
  localparam int unsigned ACK_CYCLES   = ACK_PULSE_NS / CLK_NS;
endpackage

// ==== hw/vic_if.sv ====
// Interface joining the controller to its processor-side driver
`timescale 1ns/1ps
`default_nettype none
interface vic_if;
  logic       cs;        // Chip select, one-cycle write strobe
  logic       wr;        // Write strobe
  logic       a0;        // Address bit
  logic [7:0] wdata;     // Write data
  logic       cpu_request;
  logic       ack;       // cpu_ack_strobe, high while pulse active
  logic [7:0] rdata;     // Data bus driven by device
  logic       rdata_oe;
  modport dev (input cs, wr, a0, wdata, ack, output cpu_request, rdata, rdata_oe);
  modport cpu (output cs, wr, a0, wdata, ack, input cpu_request, rdata, rdata_oe);
endinterface
`default_nettype wire

// ==== hw/vic_device.sv ====
// Vectored interrupt controller, device end
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module vic_device #(
  parameter int unsigned N = vic_pkg::NUM_LINES
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  vic_if.dev                bus,
  input  wire logic [N-1:0] request_lines_i,
  input  wire logic         master_pin_i,
  input  wire logic [2:0]   slave_id_in_i,
  output logic [2:0]        slave_id_out_o,
  output logic              slave_id_oe_o,
  output logic              buffer_enable_o,
  output logic [N-1:0]      pending_o,
  output logic [N-1:0]      in_service_o
);
  typedef enum logic [2:0] {
    VIC_IDLE = 3'b000, VIC_IW2 = 3'b001, VIC_IW3 = 3'b011, VIC_IW4 = 3'b010, VIC_RUN = 3'b110
  } vic_init_t;
  typedef enum logic [1:0] {
    VIC_A0 = 2'b00, VIC_A1 = 2'b01, VIC_A2 = 2'b11
  } vic_ack_t;

  vic_init_t   init_st;
  vic_ack_t    ack_st;
  logic [7:0]  iw1, iw2, iw3, iw4;
  logic [N-1:0] mask_bits, pending_request_bits, in_service_bits;
  logic        special_mask;
  logic [N-1:0] req_s1, req_s2, req_prev;
  logic [2:0]  id_s1, id_s2;
  logic        pin_s1, pin_s2, ack_s1, ack_s2, ack_prev;
  logic [2:0]  level;
  logic [2:0]  cas_id;
  logic        own_vector;
  logic [7:0]  data_out;
  logic        data_oe;

  // Two-flop synchronisers for pins
  always_ff @(posedge clk_i) begin
    req_s1 <= request_lines_i;
    req_s2 <= req_s1;
    id_s1  <= slave_id_in_i;
    id_s2  <= id_s1;
    pin_s1 <= master_pin_i;
    pin_s2 <= pin_s1;
    ack_s1 <= bus.ack;
    ack_s2 <= ack_s1;
  end

  wire write_cmd    = bus.cs & bus.wr;
  wire level_mode   = iw1[vic_pkg::IW1_LEVEL];
  wire spacing_four = iw1[vic_pkg::IW1_SPACING];
  wire two_pulse    = iw4[vic_pkg::IW4_FAMILY];
  wire auto_done    = iw4[vic_pkg::IW4_AUTO];
  wire buffered     = iw4[vic_pkg::IW4_BUF];
  wire special_nest = iw4[vic_pkg::IW4_NEST];
  wire is_master    = buffered ? iw4[vic_pkg::IW4_MSEL] : pin_s2;
  wire running      = (init_st == VIC_RUN);
  wire ack_rise     = ack_s2 & ~ack_prev;
  wire ack_fall     = ~ack_s2 & ack_prev;
  wire last_pulse   = two_pulse ? (ack_st == VIC_A1) : (ack_st == VIC_A2);

  // Edge or level request capture
  wire [N-1:0] edge_hit = level_mode ? req_s2 : (req_s2 & ~req_prev);
  // Effective in-service for priority: masked lines drop out under special mask
  wire [N-1:0] isr_eff  = special_mask ? (in_service_bits & ~mask_bits) : in_service_bits;
  wire [N-1:0] req_eff  = pending_request_bits & ~mask_bits;

  // Fully nested priority resolution, line 0 highest
  logic [2:0] req_lvl, isr_lvl;
  logic       req_any, isr_any;
  always_comb begin
    req_lvl = 3'h0;
    req_any = 1'b0;
    isr_lvl = 3'h0;
    isr_any = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_eff[i]) begin
        req_lvl = 3'(i);
        req_any = 1'b1;
      end
      if (isr_eff[i]) begin
        isr_lvl = 3'(i);
        isr_any = 1'b1;
      end
    end
  end
  // Special nesting lets a line at the same level through (cascaded slaves)
  wire grant_ok = req_any &
                  (!isr_any | (req_lvl < isr_lvl) | (special_nest & req_lvl == isr_lvl));

  // Initialization sequence and operation words
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      init_st      <= VIC_IDLE;
      iw1          <= 8'h00;
      iw2          <= 8'h00;
      iw3          <= 8'h00;
      iw4          <= 8'h00;
      mask_bits    <= '0;
      special_mask <= 1'b0;
    end else if (write_cmd) begin
      if (!bus.a0 && bus.wdata[vic_pkg::IW1_TAG]) begin
        init_st   <= VIC_IW2;
        iw1       <= bus.wdata;
        iw4       <= 8'h00;
        mask_bits <= '0;
        special_mask <= 1'b0;
      end else begin
        case (init_st)
          VIC_IW2: begin
            iw2 <= bus.wdata;
            if (!iw1[vic_pkg::IW1_SINGLE]) init_st <= VIC_IW3;
            else if (iw1[vic_pkg::IW1_FOURTH]) init_st <= VIC_IW4;
            else init_st <= VIC_RUN;
          end
          VIC_IW3: begin
            iw3 <= bus.wdata;
            init_st <= iw1[vic_pkg::IW1_FOURTH] ? VIC_IW4 : VIC_RUN;
          end
          VIC_IW4: begin
            iw4 <= bus.wdata;
            init_st <= VIC_RUN;
          end
          VIC_RUN: begin
            if (bus.a0) mask_bits <= bus.wdata;
            else if (bus.wdata[vic_pkg::OW_SEL_BIT] && bus.wdata[vic_pkg::OW3_ESMM])
              special_mask <= bus.wdata[vic_pkg::OW3_SMM];
          end
          default: init_st <= VIC_IDLE;
        endcase
      end
    end
  end

  // Non-specific service-done command
  wire done_cmd = write_cmd & running & ~bus.a0 & ~bus.wdata[vic_pkg::IW1_TAG] &
                  ~bus.wdata[vic_pkg::OW_SEL_BIT] & bus.wdata[vic_pkg::OW2_DONE];
  wire [N-1:0] done_clr = (done_cmd && isr_any) ? (N'(1) << isr_lvl) : '0;
  wire [N-1:0] grant    = (ack_rise && ack_st == VIC_A0 && req_any) ? (N'(1) << req_lvl) : '0;
  wire [N-1:0] auto_clr = (ack_fall && last_pulse && auto_done) ? (N'(1) << level) : '0;

  // Pending and in-service registers; a new request wins over the grant clear
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      req_prev             <= '0;
      ack_prev             <= 1'b0;
      pending_request_bits <= '0;
      in_service_bits      <= '0;
    end else begin
      req_prev <= req_s2;
      ack_prev <= ack_s2;
      pending_request_bits <= running ? ((pending_request_bits & ~grant) | edge_hit) : '0;
      in_service_bits <= running ? ((in_service_bits | grant) & ~done_clr & ~auto_clr) : '0;
    end
  end

  // Acknowledge pulse counter; level latched on the first pulse
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ack_st <= VIC_A0;
      level  <= 3'h0;
      cas_id <= 3'h0;
    end else if (ack_fall) begin
      case (ack_st)
        VIC_A0:  ack_st <= VIC_A1;
        VIC_A1:  ack_st <= two_pulse ? VIC_A0 : VIC_A2;
        VIC_A2:  ack_st <= VIC_A0;
        default: ack_st <= VIC_A0;
      endcase
    end else if (ack_rise && ack_st == VIC_A0) begin
      level  <= req_lvl;
      cas_id <= req_lvl;
    end
  end

  // Whether this device supplies the vector bytes
  wire slave_attached = is_master & iw3[level] & ~iw1[vic_pkg::IW1_SINGLE];
  wire slave_match    = (id_s2 == iw3[2:0]);
  assign own_vector   = iw1[vic_pkg::IW1_SINGLE] | (is_master ? ~slave_attached : slave_match);

  // Vector byte formation
  wire [7:0] low4  = {iw1[7:5], level, 2'b00};
  wire [7:0] low8  = {iw1[7:6], level, 3'b000};
  wire [7:0] low_b = spacing_four ? low4 : low8;
  wire [7:0] vec86 = {iw2[7:3], level};

  always_comb begin
    data_out = 8'h00;
    data_oe  = 1'b0;
    if (ack_s2 && running) begin
      case (ack_st)
        VIC_A0: begin
          data_out = vic_pkg::CALL_OPCODE;
          data_oe  = ~two_pulse & (is_master | iw1[vic_pkg::IW1_SINGLE]);
        end
        VIC_A1: begin
          data_out = two_pulse ? vec86 : low_b;
          data_oe  = own_vector;
        end
        VIC_A2: begin
          data_out = iw2;
          data_oe  = own_vector;
        end
        default: begin
          data_out = 8'h00;
          data_oe  = 1'b0;
        end
      endcase
    end
  end

  // Registered bus outputs
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      bus.rdata    <= 8'h00;
      bus.rdata_oe <= 1'b0;
      bus.cpu_request <= 1'b0;
    end else begin
      bus.rdata    <= data_out;
      bus.rdata_oe <= data_oe;
      bus.cpu_request <= running & grant_ok & (ack_st == VIC_A0);
    end
  end

  // Cascade and buffer-enable pins
  assign slave_id_out_o  = cas_id;
  assign slave_id_oe_o   = running & is_master & ~iw1[vic_pkg::IW1_SINGLE] &
                           (ack_st != VIC_A0);
  assign buffer_enable_o = buffered & bus.rdata_oe;
  assign pending_o       = pending_request_bits;
  assign in_service_o    = in_service_bits;
endmodule
`default_nettype wire

// ==== hw/vic_cpu.sv ====
// Processor-side end: Avalon-MM slave issuing writes and acknowledge pulses
`timescale 1ns/1ps
`default_nettype none
module vic_cpu #(
  parameter int unsigned ACK_CYCLES = vic_pkg::ACK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [2:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  vic_if.cpu               bus
);
  typedef enum logic [1:0] {
    VIC_C_IDLE = 2'b00, VIC_C_LOW = 2'b01, VIC_C_GAP = 2'b11
  } vic_cpu_t;

  vic_cpu_t    st;
  logic [15:0] cnt;
  logic [1:0]  pulses_left;
  logic [7:0]  last_byte;
  logic        req_s1, req_s2;
  logic        rd_ready;

  // Request from device synchronised
  always_ff @(posedge clk_i) begin
    req_s1 <= bus.cpu_request;
    req_s2 <= req_s1;
  end

  wire is_cmd  = (address_i == vic_pkg::REG_CMD);
  wire is_data = (address_i == vic_pkg::REG_DATA);
  wire is_ack  = (address_i == vic_pkg::REG_ACK);
  wire busy    = (st != VIC_C_IDLE);
  // Stall while a pulse train runs; a read waits one cycle so its data stands registered
  assign waitrequest_o = (busy & (write_i | read_i)) | (read_i & ~rd_ready);

  wire [31:0] rd_mux = (address_i == vic_pkg::REG_STATUS) ? {30'h0, busy, req_s2} :
                       (address_i == vic_pkg::REG_VECTOR) ? {24'h0, last_byte} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st          <= VIC_C_IDLE;
      cnt         <= 16'h0;
      pulses_left <= 2'h0;
      last_byte   <= 8'h00;
      readdata_o  <= 32'h0;
      rd_ready    <= 1'b0;
      bus.cs      <= 1'b0;
      bus.wr      <= 1'b0;
      bus.a0      <= 1'b0;
      bus.wdata   <= 8'h00;
      bus.ack     <= 1'b0;
    end else begin
      bus.cs <= 1'b0;
      bus.wr <= 1'b0;
      rd_ready <= read_i & ~busy & ~rd_ready;
      if (read_i && !busy && !rd_ready) readdata_o <= rd_mux;
      case (st)
        VIC_C_IDLE: begin
          if (write_i && (is_cmd || is_data)) begin
            bus.cs    <= 1'b1;
            bus.wr    <= 1'b1;
            bus.a0    <= is_data;
            bus.wdata <= writedata_i[7:0];
          end else if (write_i && is_ack) begin
            pulses_left <= writedata_i[1:0]; // Three-pulse or two-pulse count
            bus.ack     <= 1'b1;
            cnt         <= 16'(ACK_CYCLES);
            st          <= VIC_C_LOW;
          end
        end
        VIC_C_LOW: begin
          if (cnt == 16'h0) begin
            if (bus.rdata_oe) last_byte <= bus.rdata;
            bus.ack     <= 1'b0;
            pulses_left <= pulses_left - 2'h1;
            cnt         <= 16'(ACK_CYCLES);
            st          <= VIC_C_GAP;
          end else begin
            cnt <= cnt - 16'h1;
          end
        end
        VIC_C_GAP: begin
          if (cnt != 16'h0) cnt <= cnt - 16'h1;
          else if (pulses_left == 2'h0) st <= VIC_C_IDLE;
          else begin
            bus.ack <= 1'b1;
            cnt     <= 16'(ACK_CYCLES);
            st      <= VIC_C_LOW;
          end
        end
        default: st <= VIC_C_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/vic_sva.sv ====
// Checker of the acknowledge handshake on the link between both ends
`timescale 1ns/1ps
`default_nettype none
module vic_sva #(
  parameter int unsigned ACK_CYCLES = 4
) (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic       cs,
  input wire logic       wr,
  input wire logic       a0,
  input wire logic [7:0] wdata,
  input wire logic       cpu_request,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       rdata_oe
);
  logic       ack_q;
  logic [5:0] lo_cnt;
  logic [5:0] hi_cnt;
  logic [1:0] idx;
  logic [1:0] step;
  logic [4:0] ack_hist;
  logic [7:0] iw1;
  logic [7:0] iw2;
  logic [7:0] iw4;
  // Decoded writes and the acknowledge mode in force
  wire cmd_wr = cs && wr && !a0;
  wire dat_wr = cs && wr && a0;
  wire two_p  = iw1[0] && iw4[0];
  wire gap    = lo_cnt > 2 * ACK_CYCLES;
  // Pulse index within a train and a copy of init words one, two and four
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      {ack_q, idx, step, ack_hist, hi_cnt, iw1, iw2, iw4} <= '0;
      lo_cnt <= 6'h3f;
    end else begin
      ack_q    <= ack;
      ack_hist <= {ack_hist[3:0], ack};
      lo_cnt   <= ack ? 6'h00 : (lo_cnt == 6'h3f ? lo_cnt : lo_cnt + 6'h01);
      hi_cnt   <= ack ? hi_cnt + 6'h01 : 6'h00;
      if (ack && !ack_q) idx <= gap ? 2'h1 : idx + 2'h1;
      if (cmd_wr && wdata[4]) begin
        iw1  <= wdata;
        iw4  <= 8'h00;
        step <= 2'h1;
      end else if (dat_wr && step == 2'h1) begin
        iw2  <= wdata;
        step <= !iw1[1] ? 2'h2 : (iw1[0] ? 2'h3 : 2'h0);
      end else if (dat_wr && step == 2'h2) begin
        step <= iw1[0] ? 2'h3 : 2'h0;
      end else if (dat_wr && step == 2'h3) begin
        iw4  <= wdata;
        step <= 2'h0;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_opcode; rdata_oe && idx == 2'h1 |-> rdata == 8'hcd; endproperty
  a_opcode: assert property (p_opcode) else $error("first byte not call opcode");
  property p_quiet; rdata_oe && idx == 2'h1 |-> !two_p; endproperty
  a_quiet: assert property (p_quiet) else $error("bus driven on first pulse");
  property p_low4;
    rdata_oe && idx == 2'h2 && !two_p && iw1[2] |-> rdata[7:5] == iw1[7:5] && rdata[1:0] == 2'h0;
  endproperty
  a_low4: assert property (p_low4) else $error("low byte wrong, spacing four");
  property p_low8;
    rdata_oe && idx == 2'h2 && !two_p && !iw1[2] |-> rdata[7:6] == iw1[7:6] && rdata[2:0] == 3'h0;
  endproperty
  a_low8: assert property (p_low8) else $error("low byte wrong, spacing eight");
  property p_high; rdata_oe && idx == 2'h3 |-> rdata == iw2; endproperty
  a_high: assert property (p_high) else $error("high byte wrong");
  property p_vec; rdata_oe && idx == 2'h2 && two_p |-> rdata[7:3] == iw2[7:3]; endproperty
  a_vec: assert property (p_vec) else $error("vector base bits wrong");
  property p_three; $rose(ack) |-> gap || idx != 2'h3; endproperty
  a_three: assert property (p_three) else $error("more than three pulses");
  property p_two; $rose(ack) && two_p |-> gap || idx != 2'h2; endproperty
  a_two: assert property (p_two) else $error("third pulse in two-pulse mode");
  property p_cause; $rose(rdata_oe) |-> ack || (|ack_hist); endproperty
  a_cause: assert property (p_cause) else $error("bus driven without pulse");
  property p_release; $fell(ack) |-> ##[0:6] !rdata_oe; endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_width; $fell(ack) |-> hi_cnt == ACK_CYCLES + 1; endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
  c_call: cover property (rdata_oe && idx == 2'h3);
  c_vec: cover property (rdata_oe && idx == 2'h2 && two_p);
  c_req: cover property ($rose(cpu_request));
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench joining the device end and the processor end
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [2:0]  address = 3'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  req = 8'h00;
  logic [7:0]  pend;
  logic [7:0]  insv;
  logic [7:0]  seen[$];
  logic        oe_q = 1'b0;
  logic [7:0]  rd_q = 8'h00;
  logic [31:0] q;
  logic [2:0]  cas_id;
  logic        cas_oe;
  logic [2:0]  cas_seen = 3'h0;
  int          errors = 0;
  int          compares = 0;
  vic_if vic_if_i();
  vic_device vic_device_i(.clk_i(clk_i), .nrst_i(nrst_i), .bus(vic_if_i.dev),
    .request_lines_i(req), .master_pin_i(1'b1), .slave_id_in_i(3'h0), .slave_id_out_o(cas_id),
    .slave_id_oe_o(cas_oe), .buffer_enable_o(), .pending_o(pend), .in_service_o(insv));
  vic_cpu #(.ACK_CYCLES(4)) vic_cpu_i(.clk_i(clk_i), .nrst_i(nrst_i), .address_i(address),
    .read_i(read), .write_i(write), .writedata_i(writedata), .readdata_o(readdata),
    .waitrequest_o(waitrequest), .bus(vic_if_i.cpu));
  vic_sva #(.ACK_CYCLES(4)) vic_sva_i(.clk_i(clk_i), .nrst_i(nrst_i), .cs(vic_if_i.cs),
    .wr(vic_if_i.wr), .a0(vic_if_i.a0), .wdata(vic_if_i.wdata),
    .cpu_request(vic_if_i.cpu_request), .ack(vic_if_i.ack), .rdata(vic_if_i.rdata),
    .rdata_oe(vic_if_i.rdata_oe));
  always #2.5 clk_i = ~clk_i;
  // Collects each byte the device drove, once it lets go of the bus
  always @(negedge clk_i) begin
    oe_q <= vic_if_i.rdata_oe;
    rd_q <= vic_if_i.rdata;
    if (oe_q && !vic_if_i.rdata_oe) seen.push_back(rd_q);
    if (cas_oe) cas_seen <= cas_id;
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One Avalon transfer; read data lands in q
  task automatic av(input logic [2:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    do begin @(posedge clk_i); n++; end while (waitrequest !== 1'b0 && n < 500);
    if (waitrequest !== 1'b0) begin errors++; conclude(); end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic look;
    av(vic_pkg::REG_STATUS, 1'b0, 32'h0);
    @(negedge clk_i);
  endtask
  task automatic wreq;
    int k;
    k = 0;
    do begin look(); k++; end while (q[0] !== 1'b1 && k < 50);
    `CHK("request", 1'b1, q[0])
    if (q[0] !== 1'b1) conclude();
  endtask
  task automatic init(input logic [7:0] w1, w2, w3, w4, m);
    av(vic_pkg::REG_CMD, 1'b1, {24'h0, w1});
    av(vic_pkg::REG_DATA, 1'b1, {24'h0, w2});
    if (!w1[1]) av(vic_pkg::REG_DATA, 1'b1, {24'h0, w3});
    if (w1[0]) av(vic_pkg::REG_DATA, 1'b1, {24'h0, w4});
    av(vic_pkg::REG_DATA, 1'b1, {24'h0, m});
  endtask
  // Acknowledge train of n pulses expecting nb driven bytes
  task automatic train(input int n, input int nb);
    int k;
    seen.delete();
    av(vic_pkg::REG_ACK, 1'b1, n);
    k = 0;
    do begin look(); k++; end while (q[1] !== 1'b0 && k < 100);
    if (q[1] !== 1'b0) begin errors++; conclude(); end
    k = 0;
    while (seen.size() < nb && k < 40) begin @(negedge clk_i); k++; end
    `CHK("bytes", nb, seen.size())
    if (seen.size() < nb) conclude();
    while (seen.size() < 3) seen.push_back(8'h00);
  endtask
  task automatic done_cmd;
    av(vic_pkg::REG_CMD, 1'b1, 32'h20);
    av(3'h7, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, q)
    look();
  endtask
  task automatic t_call4;
    init(8'hb7, 8'h5a, 8'h00, 8'h00, 8'h00);
    req <= 8'h08;
    wreq();
    `CHK("pending", 8'h08, pend)
    train(3, 3);
    `CHK("opcode", 8'hcd, seen[0])
    `CHK("low4", 8'hac, seen[1])
    `CHK("high", 8'h5a, seen[2])
    `CHK("insv", 8'h08, insv)
    `CHK("pend", 8'h00, pend)
    @(posedge clk_i) req <= 8'h00;
    done_cmd();
    `CHK("insv done", 8'h00, insv)
    $display("t_call4 finished");
  endtask
  task automatic t_nest8;
    init(8'h53, 8'h3c, 8'h00, 8'h00, 8'h00);
    req <= 8'h24;
    wreq();
    train(3, 3);
    `CHK("low8", 8'h50, seen[1])
    `CHK("high", 8'h3c, seen[2])
    `CHK("insv", 8'h04, insv)
    look();
    `CHK("blocked", 1'b0, q[0])
    done_cmd();
    wreq();
    train(3, 3);
    `CHK("next", 8'h68, seen[1])
    `CHK("insv", 8'h20, insv)
    @(posedge clk_i) req <= 8'h00;
    done_cmd();
    $display("t_nest8 finished");
  endtask
  task automatic t_vec;
    init(8'h1b, 8'hc8, 8'h00, 8'h03, 8'h01);
    req <= 8'h41;
    wreq();
    train(2, 1);
    `CHK("vector", 8'hce, seen[0])
    `CHK("auto", 8'h00, insv)
    look();
    `CHK("level", 8'h41, pend)
    $display("t_vec finished");
  endtask
  // Cascaded master with a slave on line 2: opcode only, slave id broadcast
  task automatic t_casc;
    init(8'h15, 8'h40, 8'h04, 8'h00, 8'h00);
    req <= 8'h04;
    wreq();
    train(3, 1);
    `CHK("master byte", 8'hcd, seen[0])
    `CHK("slave id", 3'h2, cas_seen)
    `CHK("insv", 8'h04, insv)
    @(posedge clk_i) req <= 8'h00;
    done_cmd();
    `CHK("insv done", 8'h00, insv)
    $display("t_casc finished");
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_call4();
    t_nest8();
    t_vec();
    t_casc();
    conclude();
  end
endmodule
`default_nettype wire
